// ==== spi_pkg.sv ====
package spi_pkg;
   // Register indices, byte address is four times the index
   localparam logic [7:0] IDX_GAP  = 8'hf3;
   localparam logic [7:0] IDX_STAT = 8'hf4;
   localparam logic [7:0] IDX_DATA = 8'hf5;
   localparam logic [7:0] IDX_MASK = 8'hf6;
   localparam logic [7:0] IDX_CTRL = 8'hf7;
   localparam logic [7:0] IDX_IEN  = 8'hf8;

   // Status bits
   localparam int FLG_DONE = 7;
   localparam int FLG_WRITE_COLLISION_FLAG = 6;
   localparam int FLG_OVR  = 5;
   localparam int FLG_MODE_FAULT_FLAG = 4;
   localparam int FLG_DIS  = 3;

   // Control bits
   localparam int CT_SOE  = 7;
   localparam int CT_EN   = 6;
   localparam int CT_MASTER_SELECT = 4;
   localparam int CT_CPOL = 3;
   localparam int CT_CLOCK_PHASE_SELECT = 2;

   // Interrupt enable bits
   localparam int IE_SPI = 0;
   localparam int IE_GLB = 1;

   // Reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [3:0] MASK_RST = 4'hf;
   localparam logic [1:0] IEN_RST  = 2'h0;
   localparam logic [1:0] GAP_RST  = 2'h0;

   // Sixteen clock edges per byte
   localparam logic [4:0] EDGE_LAST = 5'h0f;
   // Gap in half SPI clocks is code plus this base
   localparam logic [2:0] GAP_BASE_PH0 = 3'h1;
   localparam logic [2:0] GAP_BASE_PH1 = 3'h2;
   localparam logic [3:0] HALF_UNIT    = 4'h1;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_SHIFT = 3'b010,
      ST_GAP   = 3'b100
   } state_t;

   function automatic logic [3:0] half_len(input logic [1:0] rate);
      return HALF_UNIT << rate;
   endfunction : half_len

   function automatic logic [6:0] gap_cycles(input logic clock_phase_select, input logic [1:0] code,
                                            input logic [1:0] rate);
      logic [6:0] halves;
      halves = 7'({1'b0, code}) + (clock_phase_select ? 7'(GAP_BASE_PH1) : 7'(GAP_BASE_PH0));
      return 7'(halves * 7'(half_len(rate)));
   endfunction : gap_cycles
endpackage : spi_pkg

// ==== gap_if.sv ====
`timescale 1ns/1ns
interface gap_if;
   logic       start;
   logic [6:0] len;
   logic       busy;
   modport owner (output start, output len, input busy);
   modport timer (input start, input len, output busy);
endinterface : gap_if

// ==== pin_sync.sv ====
`timescale 1ns/1ns
module pin_sync #(
   parameter int WIDTH = 4
) (
   // System
   input  wire logic             clk_sys_i,
   input  wire logic             rst_i,
   // Pins and synchronised copy
   input  wire logic [WIDTH-1:0] d_i,
   output logic      [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_d;

   always_comb begin
      meta_d = d_i;
      sync_d = meta_q;
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         meta_q <= '1;
         q_o    <= '1;
      end else begin
         meta_q <= meta_d;
         q_o    <= sync_d;
      end
   end
endmodule : pin_sync

// ==== gap_timer.sv ====
`timescale 1ns/1ns
module gap_timer (
   // System
   input  wire logic clk_sys_i,
   input  wire logic rst_i,
   // Gap request and busy
   gap_if.timer      gap
);
   logic [6:0] cnt_q;
   logic [6:0] cnt_d;

   always_comb begin
      cnt_d = cnt_q;
      if (gap.start) begin
         cnt_d = gap.len;
      end else if (cnt_q != 7'h00) begin
         cnt_d = cnt_q - 7'h01;
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_q <= 7'h00;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   assign gap.busy = (cnt_q != 7'h00);
endmodule : gap_timer

// ==== spi_status_data_and_select.sv ====
`timescale 1ns/1ns
module spi_status_data_and_select (
   // System
   input  wire logic        clk_sys_i,
   input  wire logic        rst_i,
   // Avalon-MM slave
   input  wire logic [9:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   // Interrupt
   output logic             irq_o,
   // Serial clock
   input  wire logic        sck_i,
   output logic             sck_o,
   output logic             sck_oe_o,
   // Master out data
   input  wire logic        mosi_i,
   output logic             mosi_o,
   output logic             mosi_oe_o,
   // Master in data
   input  wire logic        miso_i,
   output logic             miso_o,
   output logic             miso_oe_o,
   // Slave select, active low
   input  wire logic        ss_n_i,
   output logic             ss_n_o,
   output logic             ss_n_oe_o
);
   logic [3:0]      pin_s;
   logic            sck_s, ss_n_s, miso_s, mosi_s;
   gap_if           gap ();

   // Bus group
   logic            wait_q, wait_d;
   logic [31:0]     rdata_q, rdata_d;
   logic [7:0]      idx;
   logic            wr_acc, rd_acc;

   // Core group
   spi_pkg::state_t state_q, state_d;
   logic [7:0]      ctrl_q, ctrl_d, sh_q, sh_d, rx_q, rx_d;
   logic [1:0]      gapsel_q, gapsel_d, ien_q, ien_d;
   logic [3:0]      mask_q, mask_d, hc_q, hc_d;
   logic [4:0]      e_q, e_d;
   logic            dis_q, dis_d, done_q, done_d, write_collision_flag_q, write_collision_flag_d;
   logic            ovr_q, ovr_d, mode_fault_flag_q, mode_fault_flag_d, pend_q, pend_d;
   logic            out_q, out_d, sck_q, sck_d, sck_prev_q;
   logic            gap_start;

   // Pin group
   logic            sck_oe_d, mosi_oe_d, miso_oe_d, ss_n_d, ss_n_oe_d, irq_d;

   // Derived
   logic            master, en, clock_phase_select, cpol, soe, fault, ss_active, tick, ev;
   logic            sample, last, wr_data, din;
   logic [3:0]      clr, irq_src;
   logic [7:0]      sh_n;

   pin_sync #(.WIDTH(4)) u_sync (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .d_i       ({sck_i, ss_n_i, miso_i, mosi_i}),
      .q_o       (pin_s)
   );

   gap_timer u_gap (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .gap       (gap.timer)
   );

   assign {sck_s, ss_n_s, miso_s, mosi_s} = pin_s;
   assign gap.start = gap_start;
   assign gap.len   = spi_pkg::gap_cycles(clock_phase_select, gapsel_q, ctrl_q[1:0]);

   assign idx     = avs_address_i[9:2];
   assign wr_acc  = avs_write_i & ~wait_q;
   assign rd_acc  = avs_read_i & ~wait_q;
   assign wr_data = wr_acc && (idx == spi_pkg::IDX_DATA);

   assign master    = ctrl_q[spi_pkg::CT_MASTER_SELECT];
   assign en        = ctrl_q[spi_pkg::CT_EN];
   assign clock_phase_select      = ctrl_q[spi_pkg::CT_CLOCK_PHASE_SELECT];
   assign cpol      = ctrl_q[spi_pkg::CT_CPOL];
   assign soe       = ctrl_q[spi_pkg::CT_SOE];
   assign fault     = master & ~dis_q & ~ss_n_s;
   assign ss_active = ~master & en & ~ss_n_s;
   assign tick      = (hc_q == 4'h0);
   assign ev        = (state_q == spi_pkg::ST_SHIFT) & (master ? tick : (sck_s ^ sck_prev_q));
   assign sample    = ~e_q[0] ^ clock_phase_select;
   assign din       = master ? miso_s : mosi_s;
   assign sh_n      = (ev && sample) ? {sh_q[6:0], din} : sh_q;
   assign last      = ev && (e_q == spi_pkg::EDGE_LAST);
   assign clr       = (wr_acc && idx == spi_pkg::IDX_STAT) ? avs_writedata_i[7:4] : 4'h0;
   assign irq_src   = {done_q, 1'b0, ovr_q, mode_fault_flag_q};

   // Bus: waitrequest drops for one cycle, the access takes effect there
   always_comb begin
      wait_d  = ~((avs_read_i | avs_write_i) & wait_q);
      rdata_d = rdata_q;
      if ((avs_read_i | avs_write_i) && wait_q) begin
         rdata_d = 32'h0000_0000;
         case (idx)
            spi_pkg::IDX_GAP:  rdata_d[1:0] = gapsel_q;
            spi_pkg::IDX_STAT: rdata_d[7:0] = {done_q, write_collision_flag_q, ovr_q, mode_fault_flag_q, dis_q, 3'h0};
            spi_pkg::IDX_DATA: rdata_d[7:0] = rx_q;
            spi_pkg::IDX_MASK: rdata_d[7:0] = {mask_q, 4'h0};
            spi_pkg::IDX_CTRL: rdata_d[7:0] = ctrl_q;
            spi_pkg::IDX_IEN:  rdata_d[1:0] = ien_q;
            default:           rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         wait_q  <= 1'b1;
         rdata_q <= 32'h0000_0000;
      end else begin
         wait_q  <= wait_d;
         rdata_q <= rdata_d;
      end
   end

   // Core
   always_comb begin
      state_d   = state_q;
      ctrl_d    = ctrl_q;
      sh_d      = sh_n;
      rx_d      = rx_q;
      gapsel_d  = gapsel_q;
      ien_d     = ien_q;
      mask_d    = mask_q;
      hc_d      = hc_q;
      e_d       = e_q;
      dis_d     = dis_q;
      pend_d    = pend_q;
      out_d     = out_q;
      sck_d     = sck_q;
      gap_start = 1'b0;
      // Set wins over a same-cycle clear
      done_d = done_q & ~clr[3];
      write_collision_flag_d = write_collision_flag_q & ~clr[2];
      ovr_d  = ovr_q & ~clr[1];
      mode_fault_flag_d = mode_fault_flag_q & ~clr[0];
      if (wr_acc) begin
         case (idx)
            spi_pkg::IDX_GAP:  gapsel_d = avs_writedata_i[1:0];
            spi_pkg::IDX_STAT: dis_d    = avs_writedata_i[spi_pkg::FLG_DIS];
            spi_pkg::IDX_MASK: mask_d   = avs_writedata_i[7:4];
            spi_pkg::IDX_CTRL: ctrl_d   = avs_writedata_i[7:0];
            spi_pkg::IDX_IEN:  ien_d    = avs_writedata_i[1:0];
            default:           ctrl_d   = ctrl_q;
         endcase
      end
      case (state_q)
         spi_pkg::ST_IDLE: begin
            out_d = sh_q[7];
            sck_d = cpol;
            if (ss_active) begin
               state_d = spi_pkg::ST_SHIFT;
               e_d     = 5'h00;
            end
         end
         spi_pkg::ST_SHIFT: begin
            if (master) begin
               hc_d = tick ? spi_pkg::half_len(ctrl_q[1:0]) - 4'h1 : hc_q - 4'h1;
               if (tick) begin
                  sck_d = ~sck_q;
               end
            end
            if (ev) begin
               e_d = e_q + 5'h01;
               if (!sample) begin
                  out_d = sh_q[7];
               end
            end
            if (last) begin
               e_d = 5'h00;
               if (master) begin
                  rx_d      = sh_n;
                  done_d    = 1'b1;
                  state_d   = spi_pkg::ST_GAP;
                  gap_start = 1'b1;
               end else if (done_q) begin
                  ovr_d = 1'b1;
               end else begin
                  rx_d   = sh_n;
                  done_d = 1'b1;
               end
            end
            if (!master && !ss_active) begin
               state_d = spi_pkg::ST_IDLE;
               e_d     = 5'h00;
            end
         end
         spi_pkg::ST_GAP: begin
            sck_d = cpol;
            if (!gap.busy) begin
               pend_d  = 1'b0;
               e_d     = 5'h00;
               hc_d    = spi_pkg::half_len(ctrl_q[1:0]) - 4'h1;
               out_d   = sh_q[7];
               state_d = pend_q ? spi_pkg::ST_SHIFT : spi_pkg::ST_IDLE;
            end
         end
         default: state_d = spi_pkg::ST_IDLE;
      endcase
      // Data writes; a blocked write is dropped silently
      if (wr_data && !done_q) begin
         if (master && (state_q == spi_pkg::ST_SHIFT || pend_q)) begin
            write_collision_flag_d = 1'b1;
            sh_d   = sh_n;
         end else if (!master && ss_active) begin
            write_collision_flag_d = 1'b1;
         end else begin
            sh_d = avs_writedata_i[7:0];
            if (master && state_q == spi_pkg::ST_GAP) begin
               pend_d = 1'b1;
            end else if (master && en) begin
               state_d = spi_pkg::ST_SHIFT;
               e_d     = 5'h00;
               hc_d    = spi_pkg::half_len(ctrl_q[1:0]) - 4'h1;
               out_d   = avs_writedata_i[7];
               sck_d   = cpol;
            end
         end
      end
      if (master && !en) begin
         state_d = spi_pkg::ST_IDLE;
         pend_d  = 1'b0;
      end
      // Fault overrides the master and enable bits and the state set by any software write of the same cycle
      if (fault) begin
         mode_fault_flag_d                 = 1'b1;
         ctrl_d[spi_pkg::CT_MASTER_SELECT] = 1'b0;
         ctrl_d[spi_pkg::CT_EN]   = 1'b0;
         state_d                = spi_pkg::ST_IDLE;
         pend_d                 = 1'b0;
         sck_d                  = cpol;
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         state_q    <= spi_pkg::ST_IDLE;
         ctrl_q     <= spi_pkg::CTRL_RST;
         sh_q       <= spi_pkg::DATA_RST;
         rx_q       <= spi_pkg::DATA_RST;
         gapsel_q   <= spi_pkg::GAP_RST;
         ien_q      <= spi_pkg::IEN_RST;
         mask_q     <= spi_pkg::MASK_RST;
         hc_q       <= 4'h0;
         e_q        <= 5'h00;
         dis_q      <= 1'b0;
         done_q     <= 1'b0;
         write_collision_flag_q     <= 1'b0;
         ovr_q      <= 1'b0;
         mode_fault_flag_q     <= 1'b0;
         pend_q     <= 1'b0;
         out_q      <= 1'b0;
         sck_q      <= 1'b0;
         sck_prev_q <= 1'b1;
      end else begin
         state_q    <= state_d;
         ctrl_q     <= ctrl_d;
         sh_q       <= sh_d;
         rx_q       <= rx_d;
         gapsel_q   <= gapsel_d;
         ien_q      <= ien_d;
         mask_q     <= mask_d;
         hc_q       <= hc_d;
         e_q        <= e_d;
         dis_q      <= dis_d;
         done_q     <= done_d;
         write_collision_flag_q     <= write_collision_flag_d;
         ovr_q      <= ovr_d;
         mode_fault_flag_q     <= mode_fault_flag_d;
         pend_q     <= pend_d;
         out_q      <= out_d;
         sck_q      <= sck_d;
         sck_prev_q <= sck_s;
      end
   end

   // Pins and interrupt
   always_comb begin
      sck_oe_d  = master & en;
      mosi_oe_d = master & en;
      miso_oe_d = ss_active;
      ss_n_oe_d = master & dis_q & soe;
      ss_n_d    = (state_q != spi_pkg::ST_SHIFT);
      irq_d     = (|(irq_src & mask_q)) & ien_q[spi_pkg::IE_SPI] & ien_q[spi_pkg::IE_GLB];
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         sck_oe_o  <= 1'b0;
         mosi_oe_o <= 1'b0;
         miso_oe_o <= 1'b0;
         ss_n_oe_o <= 1'b0;
         ss_n_o    <= 1'b1;
         irq_o     <= 1'b0;
      end else begin
         sck_oe_o  <= sck_oe_d;
         mosi_oe_o <= mosi_oe_d;
         miso_oe_o <= miso_oe_d;
         ss_n_oe_o <= ss_n_oe_d;
         ss_n_o    <= ss_n_d;
         irq_o     <= irq_d;
      end
   end

   assign avs_waitrequest_o = wait_q;
   assign avs_readdata_o    = rdata_q;
   assign sck_o             = sck_q;
   assign mosi_o            = out_q;
   assign miso_o            = out_q;

   // Checks
   logic [6:0] gcnt_q;
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         gcnt_q <= 7'h00;
      end else begin
         gcnt_q <= (state_q == spi_pkg::ST_GAP) ? gcnt_q + 7'h01 : 7'h00;
      end
   end

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   sequence s_byte_end;
      last && master;
   endsequence
   sequence s_gap_end;
      state_q == spi_pkg::ST_GAP && !gap.busy;
   endsequence

   chk_gap_length: assert property (s_gap_end |-> gcnt_q == gap.len)
      else $error("gap length wrong");
   chk_gap_clock_idle: assert property (s_byte_end ##1 1'b1 |-> sck_q == cpol [*2])
      else $error("clock not idle in gap");
   chk_fault_input: assert property (master && !dis_q |=> !ss_n_oe_o)
      else $error("select driven while fault input");
   chk_auto_select: assert property (master && dis_q && soe |=>
                                     ss_n_oe_o && ss_n_o == ($past(state_q) != spi_pkg::ST_SHIFT))
      else $error("auto select wrong");
   chk_slave_select_in: assert property (!master |=> !ss_n_oe_o)
      else $error("slave drives select");
   chk_done_set: assert property (s_byte_end |=> done_q && rx_q == $past(sh_n))
      else $error("done not set");
   chk_blocked_write: assert property (wr_data && done_q && master |=>
                                       $stable(sh_q) && !$rose(pend_q))
      else $error("write not blocked");
   chk_irq_level: assert property ((|(irq_src & mask_q)) && (&ien_q) |=> irq_o)
      else $error("irq missing");
   chk_irq_global: assert property (!ien_q[spi_pkg::IE_GLB] |=> !irq_o)
      else $error("irq without global enable");
   chk_write_collision_flag_set: assert property (wr_data && !done_q && master &&
                                  state_q == spi_pkg::ST_SHIFT |=> write_collision_flag_q)
      else $error("collision missed");
   chk_overrun_set: assert property (last && !master && done_q |=> ovr_q)
      else $error("overrun missed");
   chk_fault_clears: assert property (fault |=> mode_fault_flag_q && !master && !en)
      else $error("fault handling wrong");
   chk_data_read: assert property (rd_acc && idx == spi_pkg::IDX_DATA |->
                                   avs_readdata_o[7:0] == $past(rx_q))
      else $error("data read wrong");
   chk_write_starts: assert property (wr_data && !done_q && master && en && !fault &&
                                      state_q == spi_pkg::ST_IDLE |=>
                                      state_q == spi_pkg::ST_SHIFT)
      else $error("byte not started");
   chk_sample_edge: assert property (ev && sample && !last && !wr_data && !fault |=>
                                     sh_q[0] == $past(din))
      else $error("sample edge wrong");
endmodule : spi_status_data_and_select

// ==== spi_far_end.sv ====
`timescale 1ns/1ns
module spi_far_end (
   // Wire levels
   input  wire logic sck_i,
   input  wire logic mosi_i,
   input  wire logic miso_i,
   input  wire logic ss_n_i,
   // Driven by this end
   output logic      sck_o,
   output logic      mosi_o,
   output logic      miso_o,
   output logic      ss_n_o
);
   logic [7:0] tx  = 8'h00;
   logic [7:0] sh  = 8'h00;
   logic [7:0] rx  = 8'h00;
   logic [7:0] mrx = 8'h00;
   logic [7:0] cnt = 8'h00;
   // Phase 1 slave keeps its first bit through the first clock edge
   logic       late  = 1'b0;
   logic       first = 1'b0;
   initial begin
      sck_o = 1'b0;
      mosi_o = 1'b0;
      miso_o = 1'b0;
      ss_n_o = 1'b1;
   end
   // Slave role only while not acting as master
   always @(negedge ss_n_i) if (ss_n_o) begin
      sh = tx;
      first = late;
      miso_o = sh[7];
   end
   always @(posedge sck_i) if (!ss_n_i && ss_n_o) rx = {rx[6:0], mosi_i};
   always @(negedge sck_i) if (!ss_n_i && ss_n_o) begin
      if (!first) sh = {sh[6:0], 1'b0};
      first = 1'b0;
      miso_o = sh[7];
   end
   // Released line shows the inverse, never a stale bit
   always @(posedge ss_n_i) if (ss_n_o) begin
      cnt++;
      miso_o = ~miso_o;
   end
   // Phase 0 master, 400 ns link clock, stands still between frames
   task automatic xfer(input logic [7:0] b);
      #17 ss_n_o = 1'b0;
      mosi_o = b[7];
      for (int i = 0; i < 8; i++) begin
         #200 sck_o = 1'b1;
         mrx = {mrx[6:0], miso_i};
         #200 sck_o = 1'b0;
         mosi_o = b[3'(6 - i)];
      end
      #200 ss_n_o = 1'b1;
      mosi_o = ~mosi_o;
   endtask : xfer
endmodule : spi_far_end

// ==== test_spi_status_data_and_select.sv ====
`timescale 1ns/1ns
module test_spi_status_data_and_select;
   logic        clk_sys_i = 1'b0;
   logic        rst_i     = 1'b1;
   logic [9:0]  adr       = 10'h000;
   logic        rd_en     = 1'b0;
   logic        wr_en     = 1'b0;
   logic [31:0] wdat      = 32'h0;
   logic [31:0] rdat;
   logic        wreq, irq, tb_ss = 1'b1;
   logic        sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_o, ss_oe;
   logic        p_sck, p_mosi, p_miso, p_ss;
   int          fail_count = 0;
   int          num_checks = 0;
   logic [7:0]  frames;
   // Each wire resolved from its driver's enable; select has a pull-up
   wire sck_w  = sck_oe ? sck_o : p_sck;
   wire mosi_w = mosi_oe ? mosi_o : p_mosi;
   wire miso_w = miso_oe ? miso_o : p_miso;
   wire ss_w   = ss_oe ? ss_o : (p_ss & tb_ss);
   initial forever #25 clk_sys_i = ~clk_sys_i;
   spi_status_data_and_select i_spi_status_data_and_select (.clk_sys_i(clk_sys_i),
      .rst_i(rst_i), .avs_address_i(adr), .avs_read_i(rd_en), .avs_write_i(wr_en),
      .avs_writedata_i(wdat), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .irq_o(irq),
      .sck_i(sck_w), .sck_o(sck_o), .sck_oe_o(sck_oe), .mosi_i(mosi_w), .mosi_o(mosi_o),
      .mosi_oe_o(mosi_oe), .miso_i(miso_w), .miso_o(miso_o), .miso_oe_o(miso_oe),
      .ss_n_i(ss_w), .ss_n_o(ss_o), .ss_n_oe_o(ss_oe));
   spi_far_end i_spi_far_end (.sck_i(sck_w), .mosi_i(mosi_w), .miso_i(miso_w),
      .ss_n_i(ss_w), .sck_o(p_sck), .mosi_o(p_mosi), .miso_o(p_miso), .ss_n_o(p_ss));
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // Request held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
                      output logic [7:0] q);
      int n;
      n = 0;
      @(posedge clk_sys_i);
      wr_en <= w;
      rd_en <= !w;
      adr <= {idx, 2'b00};
      wdat <= {24'h0, d};
      do begin
         @(posedge clk_sys_i);
         n++;
      end while (wreq !== 1'b0 && n < 20);
      if (n >= 20) begin
         fail_count++;
         summarize();
      end
      q = rdat[7:0];
      wr_en <= 1'b0;
      rd_en <= 1'b0;
   endtask : bus
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, idx, d, q);
   endtask : wr
   task automatic rc(input string what, input logic [7:0] idx, input logic [7:0] exp);
      logic [7:0] q;
      bus(1'b0, idx, 8'h00, q);
      chk(what, q, exp);
   endtask : rc
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask : cyc
   // Bounded poll: the byte time follows the rate, not a fixed count
   task automatic wait_done();
      logic [7:0] q;
      int n;
      n = 0;
      do begin
         bus(1'b0, 8'hf4, 8'h00, q);
         n++;
      end while (q[7] !== 1'b1 && n < 200);
      if (q[7] !== 1'b1) begin
         fail_count++;
         summarize();
      end
   endtask : wait_done
   task automatic summarize();
      $display("Checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : summarize
   initial begin
      #2000000;
      fail_count++;
      summarize();
   end
   localparam logic [7:0] RIDX [7] = '{8'hf3, 8'hf4, 8'hf5, 8'hf6, 8'hf7, 8'hf8, 8'h10};
   localparam logic [7:0] REXP [7] = '{8'h00, 8'h00, 8'h00, 8'hf0, 8'h00, 8'h00, 8'h00};
   initial begin
      cyc(10);
      rst_i <= 1'b0;
      for (int i = 0; i < 7; i++) rc("reset value", RIDX[i], REXP[i]);
      wr(8'h10, 8'hff);
      rc("unmapped", 8'h10, 8'h00);
      wr(8'hf3, 8'hff);
      rc("gap select", 8'hf3, 8'h03);
      $display("Test registers done");
      wr(8'hf4, 8'h08);
      wr(8'hf7, 8'hd2);
      wr(8'hf8, 8'h03);
      chk("select oe", 8'(ss_oe), 8'h01);
      chk("select idle", 8'(ss_w), 8'h01);
      i_spi_far_end.tx = 8'h3c;
      wr(8'hf5, 8'ha5);
      cyc(10);
      chk("select active", 8'(ss_w), 8'h00);
      wait_done();
      chk("far rx", i_spi_far_end.rx, 8'ha5);
      rc("status done", 8'hf4, 8'h88);
      rc("rx buffer", 8'hf5, 8'h3c);
      chk("irq done", 8'(irq), 8'h01);
      frames = i_spi_far_end.cnt;
      wr(8'hf5, 8'h11);
      cyc(100);
      chk("blocked write", i_spi_far_end.cnt, frames);
      wr(8'hf4, 8'h88);
      rc("done cleared", 8'hf4, 8'h08);
      chk("irq cleared", 8'(irq), 8'h00);
      $display("Test master done");
      wr(8'hf5, 8'h01);
      wr(8'hf5, 8'h02);
      wait_done();
      rc("collision", 8'hf4, 8'hc8);
      chk("first byte kept", i_spi_far_end.rx, 8'h01);
      wr(8'hf4, 8'h88);
      rc("collision sticky", 8'hf4, 8'h48);
      chk("irq collision", 8'(irq), 8'h00);
      wr(8'hf4, 8'h48);
      $display("Test collision done");
      wr(8'hf4, 8'h00);
      cyc(3);
      chk("fault input", 8'(ss_oe), 8'h00);
      tb_ss <= 1'b0;
      cyc(4);
      rc("fault flag", 8'hf4, 8'h10);
      rc("fault ctrl", 8'hf7, 8'h82);
      chk("irq fault", 8'(irq), 8'h01);
      tb_ss <= 1'b1;
      wr(8'hf4, 8'h10);
      $display("Test fault done");
      wr(8'hf7, 8'hc0);
      cyc(3);
      chk("slave select in", 8'(ss_oe), 8'h00);
      wr(8'hf5, 8'h5a);
      i_spi_far_end.xfer(8'hc3);
      cyc(4);
      rc("slave done", 8'hf4, 8'h80);
      rc("slave rx", 8'hf5, 8'hc3);
      chk("slave tx", i_spi_far_end.mrx, 8'h5a);
      i_spi_far_end.xfer(8'h77);
      cyc(4);
      rc("overrun", 8'hf4, 8'ha0);
      rc("overrun keeps", 8'hf5, 8'hc3);
      wr(8'hf6, 8'h20);
      cyc(2);
      chk("irq overrun", 8'(irq), 8'h01);
      wr(8'hf6, 8'h00);
      cyc(2);
      chk("irq masked", 8'(irq), 8'h00);
      wr(8'hf4, 8'ha0);
      rc("flags cleared", 8'hf4, 8'h00);
      $display("Test slave done");
      wr(8'hf4, 8'h08);
      wr(8'hf7, 8'hde);
      i_spi_far_end.late = 1'b1;
      i_spi_far_end.tx = 8'h96;
      wr(8'hf5, 8'h69);
      wait_done();
      chk("phase 1 far rx", i_spi_far_end.rx, 8'h69);
      i_spi_far_end.tx = 8'h5c;
      wr(8'hf4, 8'h88);
      wr(8'hf5, 8'hc6);
      rc("phase 1 rx buffer", 8'hf5, 8'h96);
      wait_done();
      chk("queued far rx", i_spi_far_end.rx, 8'hc6);
      rc("queued status", 8'hf4, 8'h88);
      rc("queued rx buffer", 8'hf5, 8'h5c);
      $display("Test phase 1 done");
      summarize();
   end
endmodule : test_spi_status_data_and_select
